// ### logic_cell_pkg.sv
// Constants, register map and types shared by the logic cell files
package logic_cell_pkg;

    typedef enum logic [1:0] {
        MODE_NORMAL    = 2'b00,
        MODE_ARITH     = 2'b01,
        MODE_UPDOWN    = 2'b10,
        MODE_CLEARABLE = 2'b11
    } cell_mode_type;

    typedef enum logic [1:0] {
        FF_D  = 2'b00,
        FF_T  = 2'b01,
        FF_JK = 2'b10,
        FF_SR = 2'b11
    } ff_kind_type;

    // Register byte offsets
    localparam logic [4:0] OFS_CONTROL = 5'h00;
    localparam logic [4:0] OFS_CONFIG = 5'h04;
    localparam logic [4:0] OFS_LUT_MASK = 5'h08;
    localparam logic [4:0] OFS_POSITION = 5'h0C;
    localparam logic [4:0] OFS_STATUS = 5'h10;

    // Control fields
    localparam int CTL_RUN_BIT = 0;

    // Configuration fields
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_FF_LSB = 2;
    localparam int CFG_LOCAL_REG_BIT = 4;
    localparam int CFG_ROUTE_REG_BIT = 5;
    localparam int CFG_CARRY_LUT_BIT = 6;
    localparam int CFG_CASC_EN_BIT = 7;
    localparam int CFG_CASC_OR_BIT = 8;
    localparam int CFG_PACKED_BIT = 9;
    localparam int CFG_CE_FIRST_BIT = 10;
    localparam int CFG_WIDTH = 11;

    // Position fields
    localparam int POS_CELL_LSB = 0;
    localparam int POS_GROUP_LSB = 8;

    // Status fields
    localparam int ST_Q_BIT = 0;
    localparam int ST_LUT_BIT = 1;
    localparam int ST_END_BIT = 2;
    localparam int ST_NCELL_LSB = 4;
    localparam int ST_NGROUP_LSB = 8;
    localparam int ST_RUN_BIT = 16;

    // Values after reset
    localparam logic [CFG_WIDTH-1:0] CONFIG_RESET = 11'h000;
    localparam logic [15:0] LUT_MASK_RESET = 16'h0000;
    localparam logic [2:0] CELL_INDEX_RESET = 3'h0;
    localparam logic [5:0] GROUP_INDEX_RESET = 6'h01;

    // Chain geometry
    localparam logic [2:0] LAST_CELL_INDEX = 3'h7;
    localparam logic [5:0] GROUP_HOP = 6'h02;
    localparam logic [5:0] BREAK_GROUP = 6'h12;

endpackage

// ### cell_lut4.sv
// Four-input lookup table: any function of four variables selected from a mask
`timescale 1ns/1ps
`default_nettype none
module cell_lut4 (
    // Function and selector
    input wire logic [15:0] mask_i,
    input wire logic [3:0] sel_i,
    // Result
    output logic y_o
);
    assign y_o = mask_i[sel_i];
endmodule
`default_nettype wire

// ### cell_flop.sv
// Programmable storage element with D, T, JK and SR behaviour
`timescale 1ns/1ps
`default_nettype none
module cell_flop (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic hold_clear_i,
    input wire logic clk_en_i,
    input wire logic clear_n_i,
    input wire logic preset_n_i,
    input wire logic_cell_pkg::ff_kind_type kind_i,
    // Data
    input wire logic a_i,
    input wire logic b_i,
    output logic q_o
);
    import logic_cell_pkg::*;

    logic q_reg;
    logic q_next;
    logic kind_next;

    // J/S on a_i, K/R on b_i; with S and R both high, set wins
    always_comb begin
        kind_next = q_reg;
        case (kind_i)
            FF_D: kind_next = a_i;
            FF_T: kind_next = q_reg ^ a_i;
            FF_JK: kind_next = (a_i & ~q_reg) | (~b_i & q_reg);
            FF_SR: kind_next = a_i | (~b_i & q_reg);
            default: kind_next = a_i;
        endcase
    end

    // Clear outranks preset, both outrank the enable
    assign q_next = (hold_clear_i || !clear_n_i) ? 1'b0 :
                    !preset_n_i ? 1'b1 :
                    clk_en_i ? kind_next : q_reg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q_reg <= 1'b0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q_o = q_reg;

    property p_enable_holds;
        @(posedge clk_i) disable iff (rst_i)
        (!clk_en_i && !hold_clear_i && clear_n_i && preset_n_i) |=> $stable(q_reg);
    endproperty
    a_enable_holds: assert property (p_enable_holds)
        else $error("register changed while clock enable was low");

    property p_toggle;
        @(posedge clk_i) disable iff (rst_i)
        (kind_i == FF_T && a_i && clk_en_i && !hold_clear_i && clear_n_i && preset_n_i)
            |=> (q_reg != $past(q_reg));
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("toggle flop failed to toggle");
endmodule
`default_nettype wire

// ### programmable_logic_element.sv
// Programmable logic cell: lookup table, storage element, carry and cascade chains
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module programmable_logic_element (
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic SYS_RST_I,
    // Avalon-MM slave
    input wire logic [4:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    // Cell data inputs and chain inputs
    input wire logic DATA_IN_FIRST_I,
    input wire logic DATA_IN_SECOND_I,
    input wire logic DATA_IN_THIRD_I,
    input wire logic DATA_IN_FOURTH_I,
    input wire logic CARRY_IN_I,
    input wire logic CASCADE_IN_I,
    // Register control inputs
    input wire logic CLK_EN_I,
    input wire logic CLEAR_N_I,
    input wire logic PRESET_N_I,
    // Cell outputs
    output logic LOCAL_OUT_O,
    output logic ROW_COL_OUT_O,
    output logic CARRY_OUT_O,
    output logic CASCADE_OUT_O
);
    import logic_cell_pkg::*;

    // Register file
    logic run_reg;
    logic [CFG_WIDTH-1:0] cfg_reg;
    logic [15:0] lut_mask_reg;
    logic [2:0] cell_index_reg;
    logic [5:0] group_index_reg;
    logic wait_reg;
    logic [31:0] readdata_reg;

    // Output flops
    logic local_out_reg;
    logic route_out_reg;
    logic carry_out_reg;
    logic cascade_out_reg;

    // Bus decode
    wire request = AVS_READ_I | AVS_WRITE_I;
    wire accept = request & ~wait_reg;
    wire wr_accept = AVS_WRITE_I & ~wait_reg;
    wire sel_control = (AVS_ADDRESS_I == OFS_CONTROL);
    wire sel_config = (AVS_ADDRESS_I == OFS_CONFIG);
    wire sel_lut = (AVS_ADDRESS_I == OFS_LUT_MASK);
    wire sel_position = (AVS_ADDRESS_I == OFS_POSITION);
    wire sel_status = (AVS_ADDRESS_I == OFS_STATUS);
    // Configuration is frozen while the cell runs, so stop it to reconfigure
    wire cfg_write_ok = wr_accept & ~run_reg;

    wire [31:0] be_mask;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
            assign be_mask[gi*8 +: 8] = {8{AVS_BYTEENABLE_I[gi]}};
        end
    endgenerate

    wire [31:0] ctl_word = {31'h0, run_reg};
    wire [31:0] cfg_word = {{(32-CFG_WIDTH){1'b0}}, cfg_reg};
    wire [31:0] lut_word = {16'h0000, lut_mask_reg};
    wire [31:0] pos_word = {18'h0, group_index_reg, 5'h00, cell_index_reg};
    wire [31:0] ctl_merge = (ctl_word & ~be_mask) | (AVS_WRITEDATA_I & be_mask);
    wire [31:0] cfg_merge = (cfg_word & ~be_mask) | (AVS_WRITEDATA_I & be_mask);
    wire [31:0] lut_merge = (lut_word & ~be_mask) | (AVS_WRITEDATA_I & be_mask);
    wire [31:0] pos_merge = (pos_word & ~be_mask) | (AVS_WRITEDATA_I & be_mask);

    // Configuration fields
    wire cell_mode_type cfg_mode = cell_mode_type'(cfg_reg[CFG_MODE_LSB +: 2]);
    wire ff_kind_type cfg_ff = ff_kind_type'(cfg_reg[CFG_FF_LSB +: 2]);
    wire cfg_local_reg = cfg_reg[CFG_LOCAL_REG_BIT];
    wire cfg_route_reg = cfg_reg[CFG_ROUTE_REG_BIT];
    wire cfg_carry_lut = cfg_reg[CFG_CARRY_LUT_BIT];
    wire cfg_casc_en = cfg_reg[CFG_CASC_EN_BIT];
    wire cfg_casc_or = cfg_reg[CFG_CASC_OR_BIT];
    wire cfg_packed = cfg_reg[CFG_PACKED_BIT];
    wire cfg_ce_first = cfg_reg[CFG_CE_FIRST_BIT];

    // Chain position: hops skip one group, and no hop crosses the RAM block
    wire last_cell = (cell_index_reg == LAST_CELL_INDEX);
    wire [5:0] hop_group = group_index_reg + GROUP_HOP;
    wire chain_end = last_cell && (group_index_reg <= BREAK_GROUP) &&
                     (hop_group > BREAK_GROUP);
    wire [5:0] next_group = last_cell ? hop_group : group_index_reg;
    wire [2:0] next_cell = cell_index_reg + 3'h1;

    // Lookup table paths
    logic q;
    logic lut_out;
    logic sum_out;
    logic carry_lut;
    // Third selector is carry in or the third data input
    wire lut_third = cfg_carry_lut ? CARRY_IN_I : DATA_IN_THIRD_I;
    // Final carry cell: select carry in and pass it through the mask
    wire [3:0] normal_sel = {DATA_IN_FOURTH_I, lut_third, DATA_IN_SECOND_I,
                             DATA_IN_FIRST_I};
    // Low half of the mask is the sum table, high half the carry table
    wire [3:0] sum_sel = {1'b0, CARRY_IN_I, DATA_IN_SECOND_I, DATA_IN_FIRST_I};
    wire [3:0] carry_sel = {1'b1, CARRY_IN_I, DATA_IN_SECOND_I, DATA_IN_FIRST_I};

    cell_lut4 u_lut_main (
        .mask_i(lut_mask_reg),
        .sel_i(cfg_mode == MODE_ARITH ? sum_sel : normal_sel),
        .y_o(lut_out)
    );

    cell_lut4 u_lut_carry (
        .mask_i(lut_mask_reg),
        .sel_i(carry_sel),
        .y_o(carry_lut)
    );

    assign sum_out = lut_out;

    // Counters: third input loads the fourth, cascade in is up/down or clear
    wire cnt_toggle = q ^ CARRY_IN_I;
    wire cnt_load = DATA_IN_THIRD_I ? DATA_IN_FOURTH_I : cnt_toggle;
    wire cnt_carry_updown = CASCADE_IN_I ? (q & CARRY_IN_I) : (~q & CARRY_IN_I);
    wire cnt_carry_clear = q & CARRY_IN_I;
    wire cnt_clearable = cnt_load & CASCADE_IN_I;

    logic comb_result;
    logic carry_next;
    always_comb begin
        comb_result = lut_out;
        carry_next = CARRY_IN_I;
        case (cfg_mode)
            MODE_NORMAL: begin
                comb_result = lut_out;
                carry_next = CARRY_IN_I;
            end
            MODE_ARITH: begin
                comb_result = sum_out;
                carry_next = carry_lut;
            end
            MODE_UPDOWN: begin
                comb_result = cnt_load;
                carry_next = cnt_carry_updown;
            end
            MODE_CLEARABLE: begin
                comb_result = cnt_clearable;
                carry_next = cnt_carry_clear;
            end
            default: begin
                comb_result = lut_out;
                carry_next = CARRY_IN_I;
            end
        endcase
    end

    // Cascade: AND, or OR by inverting both inputs and the result
    wire casc_and = comb_result & CASCADE_IN_I;
    wire casc_or = ~(~comb_result & ~CASCADE_IN_I);
    wire casc_merge = cfg_casc_or ? casc_or : casc_and;
    wire casc_mode_ok = (cfg_mode == MODE_NORMAL) || (cfg_mode == MODE_ARITH);
    // A packed cell starts its own value instead of joining the chain
    wire casc_use = cfg_casc_en & casc_mode_ok & ~cfg_packed;
    wire casc_value = casc_use ? casc_merge : comb_result;
    wire casc_idle = ~cfg_casc_or;
    wire cascade_next = chain_end ? casc_idle : casc_value;
    wire carry_final = chain_end ? 1'b0 : carry_next;

    // Storage element input
    wire packed_mode = cfg_packed && (cfg_mode == MODE_NORMAL);
    wire reg_a = packed_mode ? DATA_IN_FOURTH_I : comb_result;
    wire counter_mode = (cfg_mode == MODE_UPDOWN) || (cfg_mode == MODE_CLEARABLE);
    wire ff_kind_type ff_used = ff_kind_type'(counter_mode ? FF_D : cfg_ff);
    wire reg_ce = cfg_ce_first ? DATA_IN_FIRST_I : CLK_EN_I;

    cell_flop u_flop (
        .clk_i(CLOCK_I),
        .rst_i(SYS_RST_I),
        .hold_clear_i(~run_reg),
        .clk_en_i(reg_ce),
        .clear_n_i(CLEAR_N_I),
        .preset_n_i(PRESET_N_I),
        .kind_i(ff_used),
        .a_i(reg_a),
        .b_i(DATA_IN_FOURTH_I),
        .q_o(q)
    );

    // Each output picks bypass or register on its own
    wire local_next = run_reg & (cfg_local_reg ? q : comb_result);
    wire route_next = run_reg & (cfg_route_reg ? q : comb_result);

    wire [31:0] status_word = {15'h0, run_reg, 2'h0, next_group, 1'b0, next_cell,
                               1'b0, chain_end, lut_out, q};
    wire [31:0] read_mux = sel_control ? ctl_word :
                           sel_config ? cfg_word :
                           sel_lut ? lut_word :
                           sel_position ? pos_word :
                           sel_status ? status_word : 32'h0000_0000;

    // One wait state per access keeps the read mux off the bus output path
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            wait_reg <= 1'b1;
            readdata_reg <= 32'h0000_0000;
        end else begin
            wait_reg <= ~(request & wait_reg);
            readdata_reg <= (AVS_READ_I & wait_reg) ? read_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            run_reg <= 1'b0;
        end else if (wr_accept && sel_control) begin
            run_reg <= ctl_merge[CTL_RUN_BIT];
        end
    end

    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            cfg_reg <= CONFIG_RESET;
            lut_mask_reg <= LUT_MASK_RESET;
        end else begin
            if (cfg_write_ok && sel_config) begin
                cfg_reg <= cfg_merge[CFG_WIDTH-1:0];
            end
            if (cfg_write_ok && sel_lut) begin
                lut_mask_reg <= lut_merge[15:0];
            end
        end
    end

    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            cell_index_reg <= CELL_INDEX_RESET;
            group_index_reg <= GROUP_INDEX_RESET;
        end else if (cfg_write_ok && sel_position) begin
            cell_index_reg <= pos_merge[POS_CELL_LSB +: 3];
            group_index_reg <= pos_merge[POS_GROUP_LSB +: 6];
        end
    end

    // Outputs are registered, so each cell in a chain adds one cycle of latency
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            local_out_reg <= 1'b0;
            route_out_reg <= 1'b0;
            carry_out_reg <= 1'b0;
            cascade_out_reg <= 1'b0;
        end else begin
            local_out_reg <= local_next;
            route_out_reg <= route_next;
            carry_out_reg <= run_reg & carry_final;
            cascade_out_reg <= run_reg & cascade_next;
        end
    end

    assign AVS_READDATA_O = readdata_reg;
    assign AVS_WAITREQUEST_O = wait_reg;
    assign LOCAL_OUT_O = local_out_reg;
    assign ROW_COL_OUT_O = route_out_reg;
    assign CARRY_OUT_O = carry_out_reg;
    assign CASCADE_OUT_O = cascade_out_reg;

    property p_local_bypass;
        @(posedge CLOCK_I) disable iff (SYS_RST_I)
        (run_reg && !cfg_local_reg) |=> (LOCAL_OUT_O == $past(comb_result));
    endproperty
    a_local_bypass: assert property (p_local_bypass)
        else $error("local output does not follow the table result");

    property p_route_register;
        @(posedge CLOCK_I) disable iff (SYS_RST_I)
        (run_reg && cfg_route_reg) |=> (ROW_COL_OUT_O == $past(q));
    endproperty
    a_route_register: assert property (p_route_register)
        else $error("row/column output does not follow the register");

    property p_cascade_and;
        @(posedge CLOCK_I) disable iff (SYS_RST_I)
        (run_reg && casc_use && !cfg_casc_or && !chain_end)
            |=> (CASCADE_OUT_O == ($past(comb_result) & $past(CASCADE_IN_I)));
    endproperty
    a_cascade_and: assert property (p_cascade_and)
        else $error("cascade AND result wrong");

    property p_packed_alone;
        @(posedge CLOCK_I) disable iff (SYS_RST_I)
        (run_reg && cfg_packed && !chain_end) |=> (CASCADE_OUT_O == $past(comb_result));
    endproperty
    a_packed_alone: assert property (p_packed_alone)
        else $error("packed cell joined a cascade chain");

    property p_chain_break;
        @(posedge CLOCK_I) disable iff (SYS_RST_I)
        chain_end |=> (!CARRY_OUT_O && (CASCADE_OUT_O == ($past(run_reg) & $past(casc_idle))));
    endproperty
    a_chain_break: assert property (p_chain_break)
        else $error("chain crossed the RAM block");

    property p_group_hop;
        @(posedge CLOCK_I) disable iff (SYS_RST_I)
        (last_cell && !chain_end) |-> (next_cell == 3'h0) && (next_group[0] == group_index_reg[0])
            && (next_group > group_index_reg);
    endproperty
    a_group_hop: assert property (p_group_hop)
        else $error("chain hop does not skip one group");

    property p_arith_carry;
        @(posedge CLOCK_I) disable iff (SYS_RST_I)
        (run_reg && cfg_mode == MODE_ARITH && !chain_end)
            |=> (CARRY_OUT_O == $past(lut_mask_reg[carry_sel]));
    endproperty
    a_arith_carry: assert property (p_arith_carry)
        else $error("arithmetic carry out wrong");

    property p_config_frozen;
        @(posedge CLOCK_I) disable iff (SYS_RST_I)
        (run_reg && AVS_WRITE_I) |=> ($stable(cfg_reg) && $stable(lut_mask_reg));
    endproperty
    a_config_frozen: assert property (p_config_frozen)
        else $error("configuration changed while running");

    property p_bus_answer;
        @(posedge CLOCK_I) disable iff (SYS_RST_I)
        (request && wait_reg) |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus answer not one cycle after request");
endmodule
`default_nettype wire

// ### cell_neighbours.sv
// Model of the neighbouring cells and routing that feed the logic cell
`timescale 1ns/1ps
`default_nettype none
module cell_neighbours (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wanted levels: data 1..4, carry, cascade, enable, clear_n, preset_n
    input wire logic [8:0] want_i,
    // Levels seen by the cell
    output logic [8:0] drive_o
);
    // Neighbour outputs are registered, so they move only after a clock edge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            drive_o <= 9'h180; // Unused clear and preset rest inactive high
        end else begin
            drive_o <= want_i;
        end
    end
endmodule
`default_nettype wire

// ### programmable_logic_element_tb_top.sv
// Self-checking testbench for the programmable logic cell
`timescale 1ns/1ps
`default_nettype none
module programmable_logic_element_tb_top;
    import logic_cell_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [8:0] want = 9'h180;
    logic [8:0] drive;
    logic local_out, row_out, carry_out, cascade_out;
    logic [31:0] rdata;
    logic [15:0] mask;
    int mismatches = 0;
    int checked = 0;

    always #5 clk = ~clk;

    programmable_logic_element u_programmable_logic_element (
        .CLOCK_I(clk), .SYS_RST_I(rst),
        .AVS_ADDRESS_I(avs_address), .AVS_READ_I(avs_read), .AVS_WRITE_I(avs_write),
        .AVS_WRITEDATA_I(avs_writedata), .AVS_BYTEENABLE_I(4'hF),
        .AVS_READDATA_O(avs_readdata), .AVS_WAITREQUEST_O(avs_waitrequest),
        .DATA_IN_FIRST_I(drive[0]), .DATA_IN_SECOND_I(drive[1]),
        .DATA_IN_THIRD_I(drive[2]), .DATA_IN_FOURTH_I(drive[3]),
        .CARRY_IN_I(drive[4]), .CASCADE_IN_I(drive[5]), .CLK_EN_I(drive[6]),
        .CLEAR_N_I(drive[7]), .PRESET_N_I(drive[8]),
        .LOCAL_OUT_O(local_out), .ROW_COL_OUT_O(row_out),
        .CARRY_OUT_O(carry_out), .CASCADE_OUT_O(cascade_out)
    );

    cell_neighbours u_cell_neighbours (.clk_i(clk), .rst_i(rst), .want_i(want), .drive_o(drive));

    task automatic stop_test();
        if (mismatches == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t bit got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t word got %h expected %h", $time, got, exp);
        end
    endtask

    // Request held until waitrequest is sampled low; read data taken at that edge
    task automatic bus_cycle(input logic wr, input logic [4:0] addr, input logic [31:0] data);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= addr;
        avs_writedata <= data;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        chk_bit(avs_waitrequest, 1'b0);
    endtask

    // Configuration is locked while running, so stop, load, then run
    task automatic setup(input logic [31:0] cfg, input logic [15:0] lut, input logic [31:0] pos);
        bus_cycle(1'b1, OFS_CONTROL, 32'h0);
        bus_cycle(1'b1, OFS_CONFIG, cfg);
        bus_cycle(1'b1, OFS_LUT_MASK, {16'h0000, lut});
        bus_cycle(1'b1, OFS_POSITION, pos);
        bus_cycle(1'b1, OFS_CONTROL, 32'h1);
    endtask

    // Neighbour register, cell sampling and register output each cost one edge
    task automatic apply(input logic [8:0] v);
        @(posedge clk);
        want <= v;
        repeat (4) @(posedge clk);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        stop_test();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        bus_cycle(1'b0, OFS_CONFIG, 32'h0);
        chk_word(rdata, 32'h0);
        bus_cycle(1'b0, OFS_POSITION, 32'h0);
        chk_word(rdata, 32'h100);
        bus_cycle(1'b0, 5'h14, 32'h0);
        chk_word(rdata, 32'h0);
        chk_bit(local_out, 1'b0);
        mask = 16'hA5C3;
        // Carry in always opposes data three, so the wrong table input shows
        for (int s = 0; s < 2; s++) begin
            setup(32'(s) << CFG_CARRY_LUT_BIT, mask, 32'h100);
            for (int i = 0; i < 16; i++) begin
                apply({4'b1100, ~(i[2] ^ s[0]), i[3], i[2] ^ s[0], i[1:0]});
                chk_bit(local_out, mask[i]);
                chk_bit(row_out, mask[i]);
                chk_bit(carry_out, ~(i[2] ^ s[0]));
            end
        end
        mask = 16'hE896;
        setup(32'hA1, mask, 32'h100);
        for (int i = 0; i < 8; i++) begin
            apply({4'b1111, i[2], 2'b00, i[1:0]});
            chk_bit(local_out, mask[i]);
            chk_bit(row_out, mask[i]);
            chk_bit(carry_out, mask[i + 8]);
            chk_bit(cascade_out, mask[i]);
        end
        mask = 16'h0000;
        for (int k = 0; k < 4; k++) begin
            setup(32'h10 | (32'(k) << CFG_FF_LSB), mask, 32'h100);
            apply(9'h0C0);
            chk_bit(local_out, 1'b1);
            chk_bit(row_out, 1'b0);
            apply({2'b11, k != 0, 6'h00});
            chk_bit(local_out, 1'b1);
            apply(9'h1C8);
            chk_bit(local_out, k == 1);
            apply(9'h040);
            chk_bit(local_out, 1'b0);
        end
        mask = 16'h0001;
        for (int v = 0; v < 3; v++) begin
            setup(32'h80 | (32'(v == 1) << CFG_CASC_OR_BIT) | (32'(v == 2) << CFG_PACKED_BIT),
                mask, 32'h100);
            for (int i = 0; i < 4; i++) begin
                apply({3'b110, i[1], 4'b0000, i[0]});
                chk_bit(cascade_out, (v == 0) ? (~i[0] & i[1]) :
                    (v == 1) ? (~i[0] | i[1]) : ~i[0]);
            end
        end
        // Counters: load one, hold to read the carry, then load again or clear
        for (int m = 2; m < 4; m++) begin
            setup(32'h10 | 32'(m), mask, 32'h100);
            apply(9'h1EC);
            chk_bit(local_out, 1'b1);
            apply(9'h1B0);
            chk_bit(carry_out, 1'b1);
            chk_bit(row_out, 1'b0);
            apply(9'h1CC);
            chk_bit(local_out, m == 2);
            apply(9'h190);
            chk_bit(carry_out, 1'b0);
        end
        // Packed register takes data four while the table sees an unrelated index
        setup(32'h210, mask, 32'h100);
        apply(9'h1C8);
        chk_bit(local_out, 1'b1);
        chk_bit(row_out, 1'b0);
        apply(9'h148);
        chk_bit(local_out, 1'b0);
        setup(32'h610, mask, 32'h100);
        apply(9'h189);
        chk_bit(local_out, 1'b1);
        apply(9'h1C0);
        chk_bit(local_out, 1'b1);
        setup(32'h0, mask, 32'h107);
        bus_cycle(1'b0, OFS_STATUS, 32'h0);
        chk_word(rdata & 32'h3F74, 32'h300);
        setup(32'h0, mask, 32'h1107);
        apply(9'h1D0);
        chk_bit(carry_out, 1'b0);
        chk_bit(cascade_out, 1'b1);
        bus_cycle(1'b0, OFS_STATUS, 32'h0);
        chk_word(rdata & 32'h4, 32'h4);
        bus_cycle(1'b1, OFS_CONFIG, 32'h3FF);
        bus_cycle(1'b0, OFS_CONFIG, 32'h0);
        chk_word(rdata, 32'h0);
        // Toggle flop with its input high flips on every enabled edge
        mask = 16'hFFFF;
        setup(32'h14, mask, 32'h100);
        apply(9'h0C0);
        apply(9'h1C0);
        chk_bit(local_out, 1'b0);
        @(posedge clk);
        chk_bit(local_out, 1'b1);
        stop_test();
    end
endmodule
`default_nettype wire
